// ===== rtl/rops_pkg.sv
// Purpose: Constants and types for the remappable output pin select block
// Assumes: 16-bit register port, 64 peripheral output function lines
// Notes: Function code 0 leaves a pin with no remapped output
package rops_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SEL_42_43 = 4'h0;
  localparam logic [3:0] ADDR_SEL_54_55 = 4'h1;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int SEL_W = 6;
  localparam int FUNC_N = 64;
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [15:0] RD_IDLE = 16'h0000;
  localparam logic [15:0] IMPL_MASK = 16'h3F3F;

  typedef struct packed {
    logic [5:0] pin43_func_sel;
    logic [5:0] pin42_func_sel;
    logic [5:0] pin55_func_sel;
    logic [5:0] pin54_func_sel;
    logic [15:0] rdata;
    logic [3:0] pins;
  } rops_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rops_bus_t;
endpackage : rops_pkg

// ===== rtl/rops_pin_select.sv
// Purpose: Route one of peripheral outputs 1 to 63 to each of four remappable pins
// Assumes: Peripheral outputs are synchronous to clk_sys_i
// Notes: Pin outputs are registered, so one cycle of latency to the pins
`timescale 1ns/1ps
module rops_pin_select (
  input wire logic clk_sys_i, // System clock, 200 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire rops_pkg::rops_bus_t bus_i, // Register port request
  input wire logic [63:0] periph_out_i, // Peripheral output functions
  output logic [15:0] rdata_o, // Read data, cycle after read strobe
  output logic remap_pin_42_o, // Remapped pin 42
  output logic remap_pin_43_o, // Remapped pin 43
  output logic remap_pin_54_o, // Remapped pin 54
  output logic remap_pin_55_o // Remapped pin 55
);
  rops_pkg::rops_state_t st_r;
  rops_pkg::rops_state_t st_nxt;

  // Code 0 means unassigned; line 0 is ignored so the pin stays low
  function automatic logic pick(input logic [5:0] sel, input logic [63:0] src);
    pick = (sel == 6'h00) ? 1'b0 : src[sel];
  endfunction : pick

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = rops_pkg::RD_IDLE;
    if (bus_i.wr) begin
      if (bus_i.addr == rops_pkg::ADDR_SEL_42_43) begin
        st_nxt.pin43_func_sel = bus_i.wdata[rops_pkg::HI_FIELD_LSB +: rops_pkg::SEL_W];
        st_nxt.pin42_func_sel = bus_i.wdata[rops_pkg::LO_FIELD_LSB +: rops_pkg::SEL_W];
      end else if (bus_i.addr == rops_pkg::ADDR_SEL_54_55) begin
        st_nxt.pin55_func_sel = bus_i.wdata[rops_pkg::HI_FIELD_LSB +: rops_pkg::SEL_W];
        st_nxt.pin54_func_sel = bus_i.wdata[rops_pkg::LO_FIELD_LSB +: rops_pkg::SEL_W];
      end
    end
    if (bus_i.rd) begin
      case (bus_i.addr)
        rops_pkg::ADDR_SEL_42_43: st_nxt.rdata = {2'b00, st_r.pin43_func_sel, 2'b00, st_r.pin42_func_sel};
        rops_pkg::ADDR_SEL_54_55: st_nxt.rdata = {2'b00, st_r.pin55_func_sel, 2'b00, st_r.pin54_func_sel};
        default: st_nxt.rdata = rops_pkg::RD_IDLE;
      endcase
    end
    st_nxt.pins = {pick(st_r.pin55_func_sel, periph_out_i), pick(st_r.pin54_func_sel, periph_out_i),
                   pick(st_r.pin43_func_sel, periph_out_i), pick(st_r.pin42_func_sel, periph_out_i)};
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign remap_pin_42_o = st_r.pins[0];
  assign remap_pin_43_o = st_r.pins[1];
  assign remap_pin_54_o = st_r.pins[2];
  assign remap_pin_55_o = st_r.pins[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wr_a0_s;
    bus_i.wr && bus_i.addr == rops_pkg::ADDR_SEL_42_43;
  endsequence
  sequence wr_a1_s;
    bus_i.wr && bus_i.addr == rops_pkg::ADDR_SEL_54_55;
  endsequence
  sequence rd_a0_s;
    bus_i.rd && !bus_i.wr && bus_i.addr == rops_pkg::ADDR_SEL_42_43;
  endsequence

  pin43_field_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_a0_s |=> st_r.pin43_func_sel == $past(bus_i.wdata[13:8])) else $error("pin43 field not written");
  pin42_field_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_a0_s |=> st_r.pin42_func_sel == $past(bus_i.wdata[5:0])) else $error("pin42 field not written");
  pin55_field_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_a1_s |=> st_r.pin55_func_sel == $past(bus_i.wdata[13:8])) else $error("pin55 field not written");
  pin54_field_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_a1_s |=> st_r.pin54_func_sel == $past(bus_i.wdata[5:0])) else $error("pin54 field not written");
  reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rdata_o & ~rops_pkg::IMPL_MASK) == 16'h0000) else $error("reserved bits read nonzero");
  readback_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_a0_s ##1 !bus_i.wr ##1 rd_a0_s
    |=> rdata_o == ($past(bus_i.wdata, 3) & rops_pkg::IMPL_MASK)) else $error("readback mismatch");
  rdata_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !bus_i.rd |=> rdata_o == 16'h0000) else $error("read data not idle");
  pin43_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    remap_pin_43_o == ($past(st_r.pin43_func_sel) != 6'h00 && $past(periph_out_i[st_r.pin43_func_sel])))
    else $error("pin43 routed wrong");
  pin55_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    remap_pin_55_o == ($past(st_r.pin55_func_sel) != 6'h00 && $past(periph_out_i[st_r.pin55_func_sel])))
    else $error("pin55 routed wrong");
  pin54_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    remap_pin_54_o == ($past(st_r.pin54_func_sel) != 6'h00 && $past(periph_out_i[st_r.pin54_func_sel])))
    else $error("pin54 routed wrong");
  pin_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    remap_pin_42_o == ($past(st_r.pin42_func_sel) != 6'h00 && $past(periph_out_i[st_r.pin42_func_sel])))
    else $error("pin42 routed wrong");
  hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !bus_i.wr |=> $stable(st_r.pin55_func_sel)) else $error("select changed without write");
endmodule : rops_pin_select

// ===== verification/rops_periph_model.sv
// Purpose: Peripheral output lines seen by the pin select
// Assumes: Bench holds the pattern steady between checks
// Notes: Inverting the pattern shows a pin that is stuck
`timescale 1ns/1ps
module rops_periph_model (
  input wire logic flip_i, // Invert every line
  output logic [63:0] periph_o // Peripheral output lines
);
  localparam logic [63:0] PAT = 64'hA5C30F963CF05A69;
  assign periph_o = flip_i ? ~PAT : PAT;
endmodule : rops_periph_model

// ===== verification/rops_pin_select_tb.sv
// Purpose: Self-checking bench for the remappable pin select
// Assumes: Pins reach their routed line within three cycles
// Notes: Lines are held static, so pin checks avoid races
`timescale 1ns/1ps
module rops_pin_select_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic flip = 1'b0;
  rops_pkg::rops_bus_t bus = '0;
  logic [63:0] per;
  logic [15:0] rd;
  logic [3:0] pins;
  int fails = 0;
  int samples_checked = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  rops_periph_model i_per (.flip_i(flip), .periph_o(per));
  rops_pin_select i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .periph_out_i(per), .rdata_o(rd),
    .remap_pin_42_o(pins[0]), .remap_pin_43_o(pins[1]), .remap_pin_54_o(pins[2]), .remap_pin_55_o(pins[3]));
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
    bus <= '0;
    @(posedge clk_sys_i);
  endtask : wr
  task rdc(input logic [3:0] a, input logic [15:0] e);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    bus <= '0;
    #1 chk("rdata", e, rd);
    @(posedge clk_sys_i);
  endtask : rdc
  // Codes packed as pin55, pin54, pin43, pin42
  task pinc(input logic [23:0] c);
    logic [3:0] e;
    repeat (2) begin
      flip <= ~flip;
      repeat (3) @(posedge clk_sys_i);
      #1 for (int i = 0; i < 4; i++) e[i] = (c[6*i+:6] == 6'h00) ? 1'b0 : per[c[6*i+:6]];
      chk("pins", {12'h000, e}, {12'h000, pins});
      @(posedge clk_sys_i);
    end
  endtask : pinc
  task t_reset;
    rdc(4'h0, 16'h0000);
    rdc(4'h1, 16'h0000);
    pinc(24'h000000);
  endtask : t_reset
  task t_map;
    wr(4'h0, 16'hFFFF);
    rdc(4'h0, 16'h3F3F);
    wr(4'h0, 16'h0305);
    wr(4'h1, 16'hEA15);
    rdc(4'h0, 16'h0305);
    rdc(4'h1, 16'h2A15);
    pinc({6'h2A, 6'h15, 6'h03, 6'h05});
  endtask : t_map
  task t_refuse;
    wr(4'h2, 16'h1111);
    rdc(4'h2, 16'h0000);
    rdc(4'h0, 16'h0305);
    wr(4'h1, 16'h0000);
    pinc({12'h000, 6'h03, 6'h05});
  endtask : t_refuse
  task print_verdict;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_map();
    t_refuse();
    print_verdict();
  end
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule : rops_pin_select_tb
